// ==== core/aomc_defs.vh ====
// Constants for the converter output mode control block
`ifndef AOMC_DEFS_VH
`define AOMC_DEFS_VH

// Register byte offsets
`define AOMC_REG_CTRL        12'h000
`define AOMC_REG_STATUS      12'h004
`define AOMC_REG_IRQ_STAT    12'h008
`define AOMC_REG_IRQ_MASK    12'h00c
`define AOMC_REG_LAST_SAMPLE 12'h010

// Control fields
`define AOMC_CTRL_POWER_DOWN_PIN_BIT   0
`define AOMC_CTRL_OEN_BIT    1
`define AOMC_CTRL_RESET      32'h0000_0002

// Configuration pin levels
`define AOMC_MODE_GND        2'h0
`define AOMC_MODE_THIRD      2'h1
`define AOMC_MODE_TWOTHIRD   2'h2
`define AOMC_MODE_VDD        2'h3

// Sample codes
`define AOMC_CODE_POS_FS     14'h3fff
`define AOMC_CODE_MID        14'h2000
`define AOMC_CODE_NEG_FS     14'h0000

// Recovery counts, sampling clock cycles
`define AOMC_RELOCK_CYCLES   16'd100
`define AOMC_NAP_CYCLES      16'd100
// Sleep exit time in microseconds, then cycles at 250 MHz
`define AOMC_SLEEP_US        32'd1000
`define AOMC_CLK_MHZ         32'd250
`define AOMC_SLEEP_CYCLES    (`AOMC_SLEEP_US * `AOMC_CLK_MHZ)

// Interrupt status bits
`define AOMC_IRQ_OVR_BIT     0
`define AOMC_IRQ_VALID_BIT   1
`define AOMC_IRQ_LOCK_BIT    2
`define AOMC_IRQ_W           3

`endif

// ==== core/aomc_sync2.v ====
// Two flip-flop synchroniser, one per bit
`timescale 1ns/1ps
module aomc_sync2 #(
    parameter W = 1
) (
    input  wire         clk_sys_i,
    input  wire         rstn_i,
    input  wire         ce_i,
    input  wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    reg [W-1:0] meta;
    reg [W-1:0] sync;
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            always @(posedge clk_sys_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    meta[g] <= 1'b0;
                    sync[g] <= 1'b0;
                end else if (ce_i) begin
                    meta[g] <= d_i[g];
                    sync[g] <= meta[g];
                end
            end
        end
    endgenerate
    assign q_o = sync;
endmodule

// ==== core/aomc_recovery.v ====
// Recovery counter, marks data valid after a cycle count
`timescale 1ns/1ps
module aomc_recovery #(
    parameter CW = 20
) (
    input  wire          clk_sys_i,
    input  wire          rstn_i,
    input  wire          ce_i,
    input  wire          restart_i,
    input  wire [CW-1:0] target_i,
    input  wire          hold_i,
    output reg           done_o
);
    reg [CW-1:0] count;

    always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count  <= {CW{1'b0}};
            done_o <= 1'b0;
        end else if (ce_i) begin
            if (restart_i || hold_i) begin
                count  <= {CW{1'b0}};
                done_o <= 1'b0;
            end else if (!done_o) begin
                if (count >= target_i - 1'b1) begin
                    done_o <= 1'b1;
                end else begin
                    count <= count + 1'b1;
                end
            end
        end
    end
endmodule

// ==== core/aomc_top.v ====
// Converter output mode control: format, overflow, Hi-Z, power modes
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "aomc_defs.vh"
module aomc_top #(
    parameter DW           = 14,
    parameter SLEEP_CYCLES = `AOMC_SLEEP_CYCLES
) (
    // Clock, reset, enable
    input  wire          clk_sys_i,
    input  wire          rstn_i,
    input  wire          ce_i,
    // APB slave
    input  wire          psel_i,
    input  wire          penable_i,
    input  wire          pwrite_i,
    input  wire [11:0]   paddr_i,
    input  wire [31:0]   pwdata_i,
    output reg  [31:0]   prdata_o,
    output reg           pready_o,
    output reg           pslverr_o,
    // Configuration pins and sampling clock
    input  wire [1:0]    mode_level_i,
    input  wire          sample_clk_i,
    // Quantiser result, same clock domain
    input  wire          conv_valid_i,
    input  wire [DW-1:0] conv_code_i,
    input  wire          conv_over_i,
    input  wire          conv_under_i,
    // Parallel sample outputs, status and interrupt
    output reg  [DW-1:0] sample_code_bus_o,
    output reg           range_exceeded_flag_o,
    output reg           data_oe_o,
    output reg           data_valid_o,
    output reg           dcs_on_o,
    output reg           irq_o
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation
    wire [1:0] mode_s;
    wire       sclk_s;
    aomc_sync2 #(.W(3)) u_sync (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .ce_i      (ce_i),
        .d_i       ({mode_level_i, sample_clk_i}),
        .q_o       ({mode_s, sclk_s})
    );

    ////////////////////////////////////////////////////////////////////////
    // Registers
    reg  [31:0]           ctrl;
    reg  [`AOMC_IRQ_W-1:0] irq_stat;
    reg  [`AOMC_IRQ_W-1:0] irq_mask;
    reg                   sclk_d;
    reg                   dcs_d;
    reg                   valid_d;
    reg                   sleep_d;
    reg                   sleep_exit;
    wire                  apb_wr;
    wire                  apb_rd;
    wire                  sclk_rise;
    wire                  twos_fmt;
    wire                  dcs_on;
    wire                  pwr_down;
    wire                  oe_n;
    wire                  sleep;
    wire                  nap;
    wire                  rec_done;
    wire                  rec_restart;
    reg  [19:0]           rec_target;
    wire                  ovr_now;
    reg  [DW-1:0]         next_code;
    reg  [`AOMC_IRQ_W-1:0] ev;

    assign apb_wr    = psel_i & penable_i & pwrite_i & ~pready_o;
    assign apb_rd    = psel_i & penable_i & ~pwrite_i & ~pready_o;
    assign sclk_rise = sclk_s & ~sclk_d;
    assign twos_fmt  = mode_s[1];
    assign dcs_on    = (mode_s == `AOMC_MODE_THIRD) ||
                       (mode_s == `AOMC_MODE_TWOTHIRD);
    assign pwr_down  = ctrl[`AOMC_CTRL_POWER_DOWN_PIN_BIT];
    assign oe_n      = ctrl[`AOMC_CTRL_OEN_BIT];
    assign sleep     = pwr_down & oe_n;
    assign nap       = pwr_down & ~oe_n;
    assign ovr_now   = conv_over_i | conv_under_i;

    ////////////////////////////////////////////////////////////////////////
    // Recovery after stabilizer relock, nap or sleep exit
    assign rec_restart = (dcs_on & ~dcs_d) | (sleep_d & ~sleep);

    always @* begin
        // Sleep target kept until that recovery completes
        if (sleep_exit) begin
            rec_target = SLEEP_CYCLES[19:0];
        end else if (dcs_on) begin
            rec_target = {4'h0, `AOMC_RELOCK_CYCLES};
        end else begin
            rec_target = {4'h0, `AOMC_NAP_CYCLES};
        end
    end

    aomc_recovery #(.CW(20)) u_rec (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .ce_i      (ce_i & (sclk_rise | pwr_down | rec_restart)),
        .restart_i (rec_restart),
        .target_i  (rec_target),
        .hold_i    (pwr_down),
        .done_o    (rec_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sample code formatting
    always @* begin
        if (conv_over_i) begin
            next_code = `AOMC_CODE_POS_FS;
        end else if (conv_under_i) begin
            next_code = `AOMC_CODE_NEG_FS;
        end else begin
            next_code = conv_code_i;
        end
        if (twos_fmt) begin
            next_code[DW-1] = ~next_code[DW-1];
        end
    end

    always @* begin
        ev = {`AOMC_IRQ_W{1'b0}};
        ev[`AOMC_IRQ_OVR_BIT]   = sclk_rise & conv_valid_i & ovr_now & ~pwr_down;
        ev[`AOMC_IRQ_VALID_BIT] = rec_done & ~valid_d;
        ev[`AOMC_IRQ_LOCK_BIT]  = dcs_on & ~dcs_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // Output path
    always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sclk_d                <= 1'b0;
            dcs_d                 <= 1'b0;
            valid_d               <= 1'b0;
            sleep_d               <= 1'b0;
            sleep_exit            <= 1'b0;
            sample_code_bus_o     <= `AOMC_CODE_NEG_FS;
            range_exceeded_flag_o <= 1'b0;
            data_oe_o             <= 1'b0;
            data_valid_o          <= 1'b0;
            dcs_on_o              <= 1'b0;
        end else if (ce_i) begin
            sclk_d   <= sclk_s;
            dcs_d    <= dcs_on;
            valid_d  <= rec_done;
            sleep_d  <= sleep;
            if (sleep) begin
                sleep_exit <= 1'b1;
            end else if (rec_done) begin
                sleep_exit <= 1'b0;
            end
            dcs_on_o <= dcs_on;
            if (sclk_rise && conv_valid_i && !pwr_down) begin
                sample_code_bus_o     <= next_code;
                range_exceeded_flag_o <= ovr_now;
            end
            data_oe_o    <= ~oe_n & ~pwr_down;
            data_valid_o <= rec_done & ~pwr_down;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave, one wait state
    always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl      <= `AOMC_CTRL_RESET;
            irq_mask  <= {`AOMC_IRQ_W{1'b0}};
            irq_stat  <= {`AOMC_IRQ_W{1'b0}};
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            irq_o     <= 1'b0;
        end else if (ce_i) begin
            pready_o  <= psel_i & penable_i & ~pready_o;
            pslverr_o <= 1'b0;
            if (apb_wr && paddr_i == `AOMC_REG_IRQ_STAT) begin
                irq_stat <= (irq_stat & ~pwdata_i[`AOMC_IRQ_W-1:0]) | ev;
            end else begin
                irq_stat <= irq_stat | ev;
            end
            irq_o <= |(irq_stat & irq_mask);
            if (apb_wr) begin
                case (paddr_i)
                    `AOMC_REG_CTRL:     ctrl <= {30'h0, pwdata_i[1:0]};
                    `AOMC_REG_IRQ_STAT: ;
                    `AOMC_REG_IRQ_MASK: irq_mask <= pwdata_i[`AOMC_IRQ_W-1:0];
                    default:            pslverr_o <= (paddr_i != `AOMC_REG_STATUS) &&
                                                     (paddr_i != `AOMC_REG_LAST_SAMPLE);
                endcase
            end
            if (apb_rd) begin
                case (paddr_i)
                    `AOMC_REG_CTRL:        prdata_o <= ctrl;
                    `AOMC_REG_STATUS:      prdata_o <= {25'h0, sleep, nap, mode_s,
                                                        dcs_on, twos_fmt, rec_done};
                    `AOMC_REG_IRQ_STAT:    prdata_o <= {29'h0, irq_stat};
                    `AOMC_REG_IRQ_MASK:    prdata_o <= {29'h0, irq_mask};
                    `AOMC_REG_LAST_SAMPLE: prdata_o <= {17'h0, range_exceeded_flag_o,
                                                        sample_code_bus_o};
                    default: begin
                        prdata_o  <= 32'h0000_0000;
                        pslverr_o <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule

// ==== tb/aomc_top_chk.sv ====
// Port checker for the converter output mode control block
`timescale 1ns/1ps
module aomc_chk (
    input wire        clk_sys_i,
    input wire        rstn_i,
    input wire        psel_i,
    input wire        penable_i,
    input wire [11:0] paddr_i,
    input wire        pready_o,
    input wire        pslverr_o,
    input wire [1:0]  mode_level_i,
    input wire        sample_clk_i,
    input wire [13:0] sample_code_bus_o,
    input wire        range_exceeded_flag_o,
    input wire        data_oe_o,
    input wire        data_valid_o,
    input wire        dcs_on_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    a_rdy_lat: assert property (psel_i && $rose(penable_i) |=> pready_o)
        else $error("pready late");
    a_rdy_pulse: assert property (pready_o |=> !pready_o) else $error("pready too long");
    a_err_addr: assert property (pready_o && paddr_i > 12'h010 |-> pslverr_o)
        else $error("no error on unmapped address");
    a_ok_addr: assert property (pready_o && paddr_i <= 12'h010 && paddr_i[1:0] == 2'h0
        |-> !pslverr_o) else $error("error on mapped address");
    a_dcs_mode: assert property ($stable(mode_level_i) [*6] |->
        dcs_on_o == (mode_level_i == 2'h1 || mode_level_i == 2'h2)) else $error("dcs wrong");
    a_ovr_code: assert property (data_oe_o && range_exceeded_flag_o |->
        sample_code_bus_o inside {14'h3fff, 14'h0000, 14'h1fff, 14'h2000})
        else $error("overflow code not extreme");
    a_relock: assert property ($rose(dcs_on_o) |-> ##[0:3] !data_valid_o)
        else $error("valid kept on relock");
    a_hold: assert property (data_oe_o && $past(data_oe_o) && $stable(sample_clk_i) [*6]
        |-> $stable(sample_code_bus_o)) else $error("code changed without clock edge");
endmodule
bind aomc_top aomc_chk i_chk (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .psel_i(psel_i),
    .penable_i(penable_i), .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .mode_level_i(mode_level_i), .sample_clk_i(sample_clk_i),
    .sample_code_bus_o(sample_code_bus_o), .range_exceeded_flag_o(range_exceeded_flag_o),
    .data_oe_o(data_oe_o), .data_valid_o(data_valid_o), .dcs_on_o(dcs_on_o));

// ==== tb/aomc_far_end.sv ====
// Far side model: sampling clock source and capturing pins
`timescale 1ns/1ps
module aomc_far_end (
    input  wire        clk_sys_i,
    input  wire        rstn_i,
    input  wire [13:0] code_i,
    input  wire        flag_i,
    input  wire        oe_i,
    output reg         sample_clk_o,
    output wire [14:0] pin_word_o
);
    reg [3:0]  phase;
    reg [14:0] last;
    // 50% duty, 16 system cycles, well above the minimum rate
    always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase <= 4'h0;
            sample_clk_o <= 1'b0;
        end else begin
            phase <= phase + 4'h1;
            if (phase == 4'h7 || phase == 4'hf) sample_clk_o <= ~sample_clk_o;
            if (oe_i) last <= {flag_i, code_i};
        end
    end
    // Released pins show the inverse of the last driven word
    assign pin_word_o = oe_i ? {flag_i, code_i} : ~last;
endmodule

// ==== tb/aomc_top_tb.sv ====
// Self-checking bench for the converter output mode control block
`timescale 1ns/1ps
`include "aomc_defs.vh"
`define CHK(n, e, g) chk(n, e, g)
module aomc_top_tb;
    reg clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, c_over = 0, c_under = 0;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0, rd, r;
    reg [1:0]  mode = 0;
    reg [13:0] c_code = 0;
    reg        er, expect_on = 0, no_over = 0, cvalid = 1;
    reg [14:0] held;
    wire [31:0] prdata;
    wire [13:0] code;
    wire [14:0] pin_word, w_exp;
    wire pready, pslverr, flag, oe, valid, dcs, irq, sclk;
    integer fails = 0, tests_run = 0, cyc = 0, n, m;
    reg [14:0] q[$];
    reg [14:0] w;
    aomc_top #(.SLEEP_CYCLES(50)) i_dut (.clk_sys_i(clk), .rstn_i(rstn), .ce_i(1'b1),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .mode_level_i(mode), .sample_clk_i(sclk), .conv_valid_i(cvalid), .conv_code_i(c_code),
        .conv_over_i(c_over), .conv_under_i(c_under), .sample_code_bus_o(code),
        .range_exceeded_flag_o(flag), .data_oe_o(oe), .data_valid_o(valid),
        .dcs_on_o(dcs), .irq_o(irq));
    aomc_far_end i_far (.clk_sys_i(clk), .rstn_i(rstn), .code_i(code), .flag_i(flag),
        .oe_i(oe), .sample_clk_o(sclk), .pin_word_o(pin_word));
    initial forever #2 clk = ~clk;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 40000) begin
            fails = fails + 1;
            wrap_up;
        end
    end
    task chk(input [8*10:1] nm, input [31:0] e, input [31:0] g);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("ERROR %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task wrap_up;
        begin
            $display("Checks run %0d, mismatches %0d", tests_run, fails);
            if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    task apb(input wr, input [11:0] a, input [31:0] d);
        begin
            psel <= 1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1;
            @(posedge clk);
            while (pready !== 1'b1) begin
                @(posedge clk);
            end
            rd = prdata;
            er = pslverr;
            psel <= 0;
            penable <= 0;
            @(posedge clk);
        end
    endtask
    task wait_valid;
        begin
            repeat (6) @(posedge clk);
            n = 0;
            while (valid !== 1'b1 && n < 400) begin
                @(posedge sclk);
                n = n + 1;
            end
        end
    endtask
    task stream;
        begin
            expect_on = 1;
            repeat (24) @(posedge sclk);
            expect_on = 0;
            repeat (2) @(negedge sclk);
        end
    endtask
    // Saturation, flag and format of the sample in flight
    assign w_exp[14] = c_over | c_under;
    assign w_exp[13] = (c_over ? 1'b1 : c_under ? 1'b0 : c_code[13]) ^ mode[1];
    assign w_exp[12:0] = c_over ? 13'h1fff : c_under ? 13'h0000 : c_code[12:0];
    always @(negedge sclk) begin
        r = $urandom;
        c_code <= r[13:0];
        c_over <= r[18:16] == 3'h0 && !no_over;
        c_under <= r[18:16] == 3'h1 && !no_over;
    end
    always @(posedge sclk) if (expect_on) q.push_back(w_exp);
    always @(negedge sclk) begin
        #1;
        if (q.size() > 0) begin
            w = q.pop_front();
            `CHK("pin_word", w, pin_word);
            `CHK("valid", 1'b1, valid);
        end
    end
    initial begin
        r = $urandom(11);
        repeat (8) @(posedge clk);
        rstn <= 1;
        apb(0, `AOMC_REG_CTRL, 0);
        `CHK("ctrl_rst", `AOMC_CTRL_RESET, rd);
        `CHK("oe_rst", 1'b0, oe);
        apb(0, 12'h0fc, 0);
        `CHK("unmap_err", 1'b1, er);
        `CHK("unmap_rd", 32'h0000_0000, rd);
        apb(1, `AOMC_REG_IRQ_MASK, 1);
        apb(1, `AOMC_REG_CTRL, 0);
        for (m = 0; m < 4; m = m + 1) begin
            mode <= m;
            wait_valid;
            if (m == 1) `CHK("relock", 1'b1, n >= 97 && n <= 103);
            `CHK("dcs", m == 1 || m == 2, dcs);
            stream;
        end
        `CHK("irq_set", 1'b1, irq);
        no_over = 1;
        repeat (3) @(negedge sclk);
        apb(1, `AOMC_REG_IRQ_MASK, 0);
        `CHK("irq_mask", 1'b0, irq);
        apb(1, `AOMC_REG_IRQ_MASK, 1);
        apb(1, `AOMC_REG_IRQ_STAT, 1);
        apb(0, `AOMC_REG_IRQ_STAT, 0);
        `CHK("irq_clr", 2'b00, {irq, rd[0]});
        apb(1, `AOMC_REG_CTRL, 2);
        repeat (4) @(posedge clk);
        `CHK("hiz", 1'b0, oe);
        apb(1, `AOMC_REG_CTRL, 1);
        repeat (4) @(posedge clk);
        `CHK("nap_hiz", 1'b0, oe);
        apb(1, `AOMC_REG_CTRL, 0);
        wait_valid;
        `CHK("nap_exit", 1'b1, n >= 97 && n <= 103);
        apb(1, `AOMC_REG_CTRL, 3);
        repeat (4) @(posedge clk);
        `CHK("slp_hiz", 1'b0, oe);
        apb(1, `AOMC_REG_CTRL, 0);
        wait_valid;
        `CHK("slp_exit", 1'b1, n >= 47 && n <= 53);
        stream;
        // Without quantiser valid the outputs hold their last sample
        cvalid <= 1'b0;
        repeat (2) @(negedge sclk);
        held = pin_word;
        repeat (3) @(negedge sclk);
        `CHK("cv_hold", held, pin_word);
        wrap_up;
    end
endmodule
